// ### src/pwr_clk_ctrl.sv
`timescale 1ns/1ps
module pwr_clk_ctrl
  import pwr_clk_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,

  // Avalon-MM slave
  input wire logic [31:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,

  // Wake-up event
  input wire logic wake_i,

  // Power enables
  output logic crystal_enable_o,
  output logic pll_enable_o,
  output logic peripheral_enable_o,
  output logic core_enable_o,

  // Clocking
  output logic pll_ref_external_o,
  output logic pll_locked_o,
  output logic pll_output_clock_en_o,
  output logic core_clk_en_o
);

  localparam int LW = $clog2(LOCK_CYCLES + 1);
  localparam logic [LW-1:0] LOCK_MAX = LW'(LOCK_CYCLES);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [7:0] pwr;
    logic [1:0] oscillator_select;
    logic ref_ext;
    logic [LW-1:0] lock_cnt;
    logic locked;
    logic [7:0] nco;
    logic pll_output_clock_en;
    logic [6:0] div_cnt;
    logic core_en;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{
    waitreq: 1'b1,
    rdata: 32'h0000_0000,
    pwr: PWR_CTRL_RST,
    oscillator_select: PLL_SEL_RST,
    ref_ext: 1'b0,
    lock_cnt: '0,
    locked: 1'b0,
    nco: 8'h00,
    pll_output_clock_en: 1'b0,
    div_cnt: 7'h00,
    core_en: 1'b0
  };

  ctrl_s q;
  ctrl_s d;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [6:0] div_limit(input logic [2:0] cd);
    logic [7:0] full;
    full = (8'h01 << cd) - 8'h01;
    return full[6:0];
  endfunction : div_limit

  function automatic logic [31:0] read_word(
    input logic [31:0] addr,
    input logic [7:0] pwr,
    input logic [1:0] oscillator_select
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    if (addr == ADDR_PWR_CTRL) begin
      w = {24'h00_0000, pwr};
    end else if (addr == ADDR_PLL_SEL) begin
      w = {30'h0000_0000, oscillator_select};
    end
    return w;
  endfunction : read_word

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic req;
  logic taken;
  logic wr_ok;
  logic [15:0] wkey;
  logic ref_ok;
  logic [7:0] nco_sum;

  assign req = avs_read_i | avs_write_i;
  assign taken = req & ~q.waitreq;
  assign wr_ok = taken & avs_write_i & avs_byteenable_i[0];
  assign wkey = avs_writedata_i[15:0];

  key_guard_if kg_pwr ();
  key_guard_if kg_pll ();

  // Power control key pair
  assign kg_pwr.access = taken;
  assign kg_pwr.first_ok = wr_ok
    & (avs_address_i == ADDR_PWR_KEY1)
    & (wkey == PWR_KEY1_VAL);
  assign kg_pwr.reg_wr = wr_ok & (avs_address_i == ADDR_PWR_CTRL);
  assign kg_pwr.second_ok = wr_ok
    & (avs_address_i == ADDR_PWR_KEY2)
    & (wkey == PWR_KEY2_VAL);
  assign kg_pwr.data = avs_writedata_i[7:0];

  // PLL select key pair
  assign kg_pll.access = taken;
  assign kg_pll.first_ok = wr_ok
    & (avs_address_i == ADDR_PLL_KEY1)
    & (wkey == PLL_KEY1_VAL);
  assign kg_pll.reg_wr = wr_ok & (avs_address_i == ADDR_PLL_SEL);
  assign kg_pll.second_ok = wr_ok
    & (avs_address_i == ADDR_PLL_KEY2)
    & (wkey == PLL_KEY2_VAL);
  assign kg_pll.data = avs_writedata_i[7:0];

  key_guard u_pwr_guard (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .kg(kg_pwr)
  );

  key_guard u_pll_guard (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .kg(kg_pll)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  assign ref_ok = (q.oscillator_select != OSCILLATOR_SELECT_EXT) | q.pwr[CRYSTAL_BIT];
  assign nco_sum = q.nco + NCO_STEP;

  always_comb begin
    d = q;

    // Bus answer one cycle after the request
    if (q.waitreq) begin
      if (req) begin
        d.waitreq = 1'b0;
        d.rdata = avs_read_i
          ? read_word(avs_address_i, q.pwr, q.oscillator_select)
          : 32'h0000_0000;
      end
    end else begin
      d.waitreq = 1'b1;
    end

    // Protected registers, bit 7 kept clear
    if (kg_pwr.commit) begin
      d.pwr = kg_pwr.value & PWR_CTRL_MASK;
    end
    if (wake_i) begin
      d.pwr = d.pwr | WAKE_SET_MASK;
    end
    if (kg_pll.commit) begin
      d.oscillator_select = kg_pll.value[1:0];
    end
    d.ref_ext = (d.oscillator_select == OSCILLATOR_SELECT_EXT);

    // PLL lock on a live reference
    if (!q.pwr[PLL_EN_BIT] || !ref_ok || kg_pll.commit) begin
      d.lock_cnt = '0;
      d.locked = 1'b0;
    end else if (q.lock_cnt == LOCK_MAX) begin
      d.locked = 1'b1;
    end else begin
      d.lock_cnt = q.lock_cnt + LW'(1);
    end

    // PLL output rate as an enable
    d.pll_output_clock_en = 1'b0;
    if (q.locked && q.pwr[PLL_EN_BIT]) begin
      if (nco_sum >= NCO_MOD) begin
        d.nco = nco_sum - NCO_MOD;
        d.pll_output_clock_en = 1'b1;
      end else begin
        d.nco = nco_sum;
      end
    end else begin
      d.nco = 8'h00;
    end

    // Core clock divider
    d.core_en = 1'b0;
    if (!q.locked) begin
      d.div_cnt = 7'h00;
    end else if (q.pll_output_clock_en) begin
      if (q.div_cnt >= div_limit(q.pwr[2:0])) begin
        d.div_cnt = 7'h00;
        d.core_en = q.pwr[CORE_BIT];
      end else begin
        d.div_cnt = q.div_cnt + 7'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q <= CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.waitreq;
  assign crystal_enable_o = q.pwr[CRYSTAL_BIT];
  assign pll_enable_o = q.pwr[PLL_EN_BIT];
  assign peripheral_enable_o = q.pwr[PERIPH_BIT];
  assign core_enable_o = q.pwr[CORE_BIT];
  assign pll_ref_external_o = q.ref_ext;
  assign pll_locked_o = q.locked;
  assign pll_output_clock_en_o = q.pll_output_clock_en;
  assign core_clk_en_o = q.core_en;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_RESET_VALUE: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |-> (q.pwr == PWR_CTRL_RST) && (q.pwr[2:0] == CD_RST)
      && crystal_enable_o && pll_enable_o && core_enable_o
  ) else $error("power control not at reset value after reset");

  AST_CRYSTAL_OFF: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (kg_pwr.commit && !kg_pwr.value[CRYSTAL_BIT]) |=> !crystal_enable_o
  ) else $error("crystal still enabled after keyed clear");

  AST_PLL_OFF_STOPS: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !pll_enable_o |=> !pll_output_clock_en_o && !core_clk_en_o
  ) else $error("PLL clock enable pulses while PLL is off");

  AST_WAKE_SETS: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    wake_i |=> pll_enable_o && peripheral_enable_o && core_enable_o
  ) else $error("wake-up did not set the enable bits");

  AST_CORE_FROM_PLL_OUTPUT_CLOCK: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    core_clk_en_o |-> $past(pll_output_clock_en_o) && $past(core_enable_o)
  ) else $error("core enable pulse not derived from PLL pulse");

  AST_FAST_DIVIDE: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (q.pwr[2:0] == 3'h0 && q.locked && core_enable_o && !kg_pwr.commit
      && !kg_pll.commit && pll_output_clock_en_o)
    |=> core_clk_en_o
  ) else $error("divider zero does not pass every PLL pulse");

  AST_REF_INTERNAL: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (kg_pll.commit && kg_pll.value[1:0] != OSCILLATOR_SELECT_EXT) |=> !pll_ref_external_o
  ) else $error("external reference chosen by a non-external code");

  AST_LOCK_DELAY: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(pll_enable_o) |-> !pll_locked_o [*8]
  ) else $error("PLL locked too soon after power-up");

  AST_PLL_OUTPUT_CLOCK_NEEDS_LOCK: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    pll_output_clock_en_o |-> $past(pll_locked_o) ##1 !pll_output_clock_en_o
  ) else $error("PLL clock pulse without lock or back to back");

  AST_PWR_COMMIT: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (kg_pwr.commit && !wake_i) |=> q.pwr == ($past(kg_pwr.value) & PWR_CTRL_MASK)
  ) else $error("keyed power write not applied");

  AST_PWR_HELD: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (!kg_pwr.commit && !wake_i) |=> $stable(q.pwr)
  ) else $error("power control changed without keyed write or wake");

  AST_SEL_HELD: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !kg_pll.commit |=> $stable(q.oscillator_select)
  ) else $error("oscillator select changed without keyed write");

  AST_REF_EXTERNAL: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (kg_pll.commit && kg_pll.value[1:0] == OSCILLATOR_SELECT_EXT) |=> pll_ref_external_o
  ) else $error("external code did not choose the crystal");

  AST_CRYSTAL_ON: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (kg_pwr.commit && kg_pwr.value[CRYSTAL_BIT]) |=> crystal_enable_o
  ) else $error("crystal not enabled after keyed set");

  AST_PERIPH_OFF: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (kg_pwr.commit && !kg_pwr.value[PERIPH_BIT] && !wake_i) |=> !peripheral_enable_o
  ) else $error("peripherals still enabled after keyed clear");

  AST_CORE_OFF: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (kg_pwr.commit && !kg_pwr.value[CORE_BIT] && !wake_i) |=> !core_enable_o
  ) else $error("core still enabled after keyed clear");

  AST_CORE_GATED: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !core_enable_o |=> !core_clk_en_o
  ) else $error("core clock pulse while core is off");

  AST_UNLOCK_WHEN_OFF: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !pll_enable_o |=> !pll_locked_o
  ) else $error("PLL reports lock while powered down");

  AST_CORE_SPACING: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    core_clk_en_o |=> !core_clk_en_o
  ) else $error("core clock pulses back to back");

  AST_PLL_OUTPUT_CLOCK_SPACING: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    pll_output_clock_en_o |=> !pll_output_clock_en_o [*2]
  ) else $error("PLL clock pulses closer than its rate allows");

endmodule : pwr_clk_ctrl

// ### src/pwr_clk_pkg.sv
// Summary of operation
// - Power control resets to 0x7B
// - Bit 6 enables crystal circuitry
// - PLL off stops PLL-clocked timers
// - PLL enable set on reset and wake
// - Bit 4 enables peripherals, set on wake
// - Bit 3 enables core, set on wake
// - Core clock is PLL clock over 2^divider
// - Divider resets to 011, 1.28 MHz
// - Select code 10 picks external crystal
// - Locked PLL gives steady 10.24 MHz clock
package pwr_clk_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [31:0] ADDR_PWR_KEY1 = 32'hFFFF0404;
  localparam logic [31:0] ADDR_PWR_CTRL = 32'hFFFF0408;
  localparam logic [31:0] ADDR_PWR_KEY2 = 32'hFFFF040C;
  localparam logic [31:0] ADDR_PLL_KEY1 = 32'hFFFF0410;
  localparam logic [31:0] ADDR_PLL_SEL = 32'hFFFF0414;
  localparam logic [31:0] ADDR_PLL_KEY2 = 32'hFFFF0418;

  localparam logic [15:0] PWR_KEY1_VAL = 16'h0001;
  localparam logic [15:0] PWR_KEY2_VAL = 16'h00F4;
  localparam logic [15:0] PLL_KEY1_VAL = 16'h00AA;
  localparam logic [15:0] PLL_KEY2_VAL = 16'h0055;

  // ------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] PWR_CTRL_RST = 8'h7B;
  localparam logic [7:0] PWR_CTRL_MASK = 8'h7F;
  localparam logic [7:0] WAKE_SET_MASK = 8'h38;
  localparam logic [2:0] CD_RST = 3'h3;
  localparam int CRYSTAL_BIT = 6;
  localparam int PLL_EN_BIT = 5;
  localparam int PERIPH_BIT = 4;
  localparam int CORE_BIT = 3;
  localparam logic [1:0] PLL_SEL_RST = 2'h0;
  localparam logic [1:0] OSCILLATOR_SELECT_EXT = 2'h2;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int PLL_HZ = 10_240_000;
  localparam int NCO_UNIT_HZ = 320_000;
  localparam logic [7:0] NCO_STEP = 8'(PLL_HZ / NCO_UNIT_HZ);
  localparam logic [7:0] NCO_MOD = 8'(CLK_HZ / NCO_UNIT_HZ);
  localparam int LOCK_TIME_NS = 1000;
  localparam int LOCK_CYCLES = (LOCK_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ------------------------------------------------------------
  // Key sequence states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    G_IDLE = 2'b00,
    G_KEYED = 2'b01,
    G_PEND = 2'b10
  } guard_state_e;

endpackage : pwr_clk_pkg

// ### src/key_guard_if.sv
`timescale 1ns/1ps
interface key_guard_if;
  logic access;
  logic first_ok;
  logic reg_wr;
  logic second_ok;
  logic [7:0] data;
  logic commit;
  logic [7:0] value;

  modport ctrl (
    output access, first_ok, reg_wr, second_ok, data,
    input commit, value
  );
  modport guard (
    input access, first_ok, reg_wr, second_ok, data,
    output commit, value
  );
endinterface : key_guard_if

// ### src/key_guard.sv
`timescale 1ns/1ps
module key_guard
  import pwr_clk_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Bus side
  key_guard_if.guard kg
);

  typedef struct packed {
    guard_state_e st;
    logic [7:0] val;
  } guard_s;

  localparam guard_s GUARD_RST = '{st: G_IDLE, val: 8'h00};

  guard_s q;
  guard_s d;

  // ------------------------------------------------------------
  // Key, write, key sequence
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    if (kg.access) begin
      unique case (q.st)
        G_IDLE: begin
          if (kg.first_ok) begin
            d.st = G_KEYED;
          end
        end
        G_KEYED: begin
          if (kg.reg_wr) begin
            d.st = G_PEND;
            d.val = kg.data;
          end else if (kg.first_ok) begin
            d.st = G_KEYED;
          end else begin
            d.st = G_IDLE;
          end
        end
        G_PEND: begin
          d.st = kg.first_ok ? G_KEYED : G_IDLE;
        end
        default: begin
          d.st = G_IDLE;
        end
      endcase
    end
  end

  // Commit only on the closing key
  assign kg.commit = kg.access & kg.second_ok & (q.st == G_PEND);
  assign kg.value = q.val;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q <= GUARD_RST;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_COMMIT_AFTER_WRITE: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(q.st == G_PEND) |-> $past(kg.access && kg.reg_wr && q.st == G_KEYED)
  ) else $error("protected write pending without preceding key and write");

  AST_NO_COMMIT_UNKEYED: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (kg.access && kg.reg_wr && q.st != G_KEYED) |=> q.st != G_PEND
  ) else $error("protected write armed without opening key");

endmodule : key_guard

// ### sim/power_and_pll_clock_control_test.sv
`timescale 1ns/1ps
module power_and_pll_clock_control_test;
  import pwr_clk_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [31:0] avs_address_i = 32'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic wake_i = 1'b0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic crystal_enable_o;
  logic pll_enable_o;
  logic peripheral_enable_o;
  logic core_enable_o;
  logic pll_ref_external_o;
  logic pll_locked_o;
  logic pll_output_clock_en_o;
  logic core_clk_en_o;
  logic [31:0] en_w;
  logic [31:0] rd;
  int n_mismatch = 0;
  int num_checks = 0;

  assign en_w = {28'h0, crystal_enable_o, pll_enable_o, peripheral_enable_o, core_enable_o};

  always #12.5 clk_i = ~clk_i;

  pwr_clk_ctrl dut (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .wake_i(wake_i),
    .crystal_enable_o(crystal_enable_o),
    .pll_enable_o(pll_enable_o),
    .peripheral_enable_o(peripheral_enable_o),
    .core_enable_o(core_enable_o),
    .pll_ref_external_o(pll_ref_external_o),
    .pll_locked_o(pll_locked_o),
    .pll_output_clock_en_o(pll_output_clock_en_o),
    .core_clk_en_o(core_clk_en_o)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_cnt(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_cnt

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rd_chk

  task automatic prot(input logic pll, input logic [7:0] v);
    bus(1'b1, pll ? ADDR_PLL_KEY1 : ADDR_PWR_KEY1, {16'h0, pll ? PLL_KEY1_VAL : PWR_KEY1_VAL});
    bus(1'b1, pll ? ADDR_PLL_SEL : ADDR_PWR_CTRL, {24'h0, v});
    bus(1'b1, pll ? ADDR_PLL_KEY2 : ADDR_PWR_KEY2, {16'h0, pll ? PLL_KEY2_VAL : PWR_KEY2_VAL});
  endtask : prot

  task automatic pulses(input int cyc, output int np, output int nc);
    np = 0;
    nc = 0;
    repeat (cyc) begin
      @(negedge clk_i);
      np += int'(pll_output_clock_en_o === 1'b1);
      nc += int'(core_clk_en_o === 1'b1);
    end
  endtask : pulses

  task automatic do_reset();
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
  endtask : do_reset

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd_chk(ADDR_PWR_CTRL, 32'h7B);
    rd_chk(ADDR_PLL_SEL, 32'h0);
    rd_chk(ADDR_PWR_KEY1, 32'h0);
    rd_chk(32'hFFFF0400, 32'h0);
    chk(en_w, 32'hF);
    chk({31'h0, pll_ref_external_o}, 32'h0);
  endtask : t_reset

  task automatic t_guard();
    bus(1'b1, ADDR_PWR_CTRL, 32'h40);
    rd_chk(ADDR_PWR_CTRL, 32'h7B);
    bus(1'b1, ADDR_PWR_KEY1, 32'h2);
    bus(1'b1, ADDR_PWR_CTRL, 32'h40);
    bus(1'b1, ADDR_PWR_KEY2, {16'h0, PWR_KEY2_VAL});
    rd_chk(ADDR_PWR_CTRL, 32'h7B);
    bus(1'b1, ADDR_PWR_KEY1, {16'h0, PWR_KEY1_VAL});
    bus(1'b1, ADDR_PWR_CTRL, 32'h40);
    rd_chk(ADDR_PWR_CTRL, 32'h7B);
    bus(1'b1, ADDR_PWR_KEY2, {16'h0, PWR_KEY2_VAL});
    rd_chk(ADDR_PWR_CTRL, 32'h7B);
    bus(1'b1, ADDR_PWR_KEY1, {16'h0, PWR_KEY1_VAL});
    avs_byteenable_i <= 4'hE;
    bus(1'b1, ADDR_PWR_CTRL, 32'h40);
    avs_byteenable_i <= 4'hF;
    bus(1'b1, ADDR_PWR_KEY2, {16'h0, PWR_KEY2_VAL});
    rd_chk(ADDR_PWR_CTRL, 32'h7B);
    bus(1'b1, ADDR_PLL_KEY1, {16'h0, PLL_KEY1_VAL});
    bus(1'b1, ADDR_PLL_SEL, 32'h2);
    bus(1'b1, ADDR_PLL_KEY2, 32'h56);
    rd_chk(ADDR_PLL_SEL, 32'h0);
    bus(1'b1, ADDR_PLL_SEL, 32'h2);
    rd_chk(ADDR_PLL_SEL, 32'h0);
  endtask : t_guard

  task automatic t_sel();
    for (int c = 0; c < 4; c++) begin
      prot(1'b1, 8'(c));
      rd_chk(ADDR_PLL_SEL, 32'(c));
      chk({31'h0, pll_ref_external_o}, {31'h0, c == 2});
    end
    prot(1'b1, 8'h0);
  endtask : t_sel

  task automatic t_div();
    int np;
    int nc;
    for (int cd = 0; cd < 8; cd++) begin
      prot(1'b0, 8'h78 | 8'(cd));
      rd_chk(ADDR_PWR_CTRL, 32'h78 | 32'(cd));
      repeat (600) @(posedge clk_i);
      chk({31'h0, pll_locked_o}, 32'h1);
      pulses(2000, np, nc);
      chk_cnt(np, 511, 513);
      chk_cnt(nc, (np >> cd) - 1, (np >> cd) + 1);
    end
    prot(1'b0, 8'h7B);
  endtask : t_div

  task automatic t_down();
    int np;
    int nc;
    prot(1'b0, 8'h03);
    repeat (2) @(posedge clk_i);
    chk(en_w, 32'h0);
    rd_chk(ADDR_PWR_CTRL, 32'h03);
    pulses(200, np, nc);
    chk_cnt(np, 0, 0);
    chk_cnt(nc, 0, 0);
    chk({31'h0, pll_locked_o}, 32'h0);
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    @(negedge clk_i);
    chk(en_w, 32'h7);
    rd_chk(ADDR_PWR_CTRL, 32'h3B);
    repeat (100) @(posedge clk_i);
    pulses(250, np, nc);
    chk_cnt(np, 63, 65);
    chk_cnt(nc, 7, 9);
    prot(1'b0, 8'h7B);
    repeat (2) @(posedge clk_i);
    chk(en_w, 32'hF);
  endtask : t_down

  task automatic t_rereset();
    prot(1'b0, 8'h38);
    prot(1'b1, 8'h2);
    do_reset();
    t_reset();
  endtask : t_rereset

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    final_report();
  end

  initial begin
    do_reset();
    t_reset();
    t_guard();
    t_sel();
    t_div();
    t_down();
    t_rereset();
    final_report();
  end

endmodule : power_and_pll_clock_control_test
